// ---- hw/sprpc_pkg.sv ----
/*
 * Shared constants, types and helpers for the pipelined dual-port RAM port logic.
 * Assumes one clock for both ports and a synchronous active-high reset.
 */
package sprpc_pkg;
    // Array shape: 32K words of four 9-bit byte lanes
    localparam int ADDR_W = 15;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = LANES * LANE_W;
    localparam int PORTS = 2;
    localparam int PORT_LEFT = 0;
    localparam int PORT_RIGHT = 1;

    // Reset and clear values
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 15'h0000;
    localparam logic [DATA_W-1:0] DATA_ZERO = 36'h000000000;
    localparam logic [LANES-1:0] LANES_OFF = 4'h0;
    localparam logic [LANES-1:0] LANES_OFF_N = 4'hF;
    localparam logic RW_READ = 1'b1;

    // Consecutive selected cycles needed before outputs come back
    localparam int REACT_CYCLES = 2;

    // Port power state: down, one selected cycle seen, fully active
    typedef enum logic [1:0] {
        PWR_DOWN,
        PWR_WAKE,
        PWR_ACTIVE
    } sprpc_pwr_t;

    // Widen a per-lane flag to a per-bit mask
    function automatic logic [DATA_W-1:0] sprpc_lane_mask(input logic [LANES-1:0] lanes);
        logic [DATA_W-1:0] mask;
        mask = DATA_ZERO;
        for (int l = 0; l < LANES; l++) begin
            mask[l*LANE_W +: LANE_W] = {LANE_W{lanes[l]}};
        end
        return mask;
    endfunction
endpackage

// ---- hw/sprpc_cnt_if.sv ----
/*
 * Carrier between a port's control logic and its burst address counter.
 * Assumes the counter and the port logic share one clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface sprpc_cnt_if #(parameter int ADDR_W = sprpc_pkg::ADDR_W);
    logic clear_n;
    logic load_n;
    logic advance_n;
    logic [ADDR_W-1:0] ext_addr;
    logic [ADDR_W-1:0] addr;

    modport ctrl (output clear_n, output load_n, output advance_n, output ext_addr, input addr);
    modport counter (input clear_n, input load_n, input advance_n, input ext_addr, output addr);
endinterface
`default_nettype wire

// ---- hw/sprpc_addr_counter.sv ----
/*
 * Burst address register of one port: clear, load, advance or hold.
 * Assumes controls are synchronous to clk and already sampled at its edge.
 */
`timescale 1ns/1ps
`default_nettype none
module sprpc_addr_counter #(
    parameter int ADDR_W = sprpc_pkg::ADDR_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Counter controls and the address accessed this cycle
    sprpc_cnt_if.counter cnt
);
    import sprpc_pkg::*;

    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] addr_next;
    logic [ADDR_W-1:0] addr_plus;

    // Increment wraps from the top word back to zero
    // (R18) fifteen-bit wrap
    assign addr_plus = addr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};

    // Next address, clear over load over advance
    // (R19) control priority order
    assign addr_next = !cnt.clear_n ? ADDR_ZERO :
                       !cnt.load_n ? cnt.ext_addr :
                       !cnt.advance_n ? addr_plus :
                       addr_reg;

    // Address register; its value is the access address after the edge
    // (R2) load every strobe
    // (R4) hold when stalled
    always_ff @(posedge clk) begin
        if (srst) begin
            addr_reg <= ADDR_ZERO;
        end else begin
            addr_reg <= addr_next;
        end
    end

    assign cnt.addr = addr_reg;
endmodule
`default_nettype wire

// ---- hw/sprpc_port_ram.sv ----
/*
 * Two-port synchronous pipelined static RAM with per-port burst counters,
 * dual chip selects with power-down, registered byte-lane writes and
 * pipelined reads with an asynchronous output enable.
 * Assumes all inputs except OE_N are synchronous to CLK; the data pins are
 * split into input, output and output enable, resolved outside.
 */
// Overview of operation
// (R1) Access address is the external one when strobed, else the counter.
// (R2) External address loads on every edge with the strobe low.
// (R3) Advance with strobe high increments and accesses the new address.
// (R4) Counter holds whenever strobe, advance and clear are all deasserted.
// (R5) Counter clear costs no idle cycle; access proceeds meanwhile.
// (R6) An access in a clear cycle uses location zero.
// (R7) Output state follows the controls sampled one cycle earlier.
// (R8) Address, data and controls are captured on the rising clock edge.
// (R9) Array write is self-timed from registered values, off the clock edge.
// (R10) Output enable gates the data drivers without the clock.
// (R11) One deselected cycle powers the port down.
// (R12) Outputs return only after two consecutive selected cycles.
// (R13) Host decodes selects so exactly one bank is chosen.
// (R14) Host drives parallel devices in common for wider words.
// (R15) Read data appears two cycles on; disabled lanes float.
// (R16) Without load or advance the same data keeps coming out.
// (R17) Deselect or lane disable floats outputs after the next edge.
// (R18) The counter is fifteen bits and wraps to zero.
// (R19) Clear beats load, load beats advance.
// (R20) Each port has its own counter and control registers.
`timescale 1ns/1ps
`default_nettype none
module sprpc_port_ram #(
    parameter int ADDR_W = sprpc_pkg::ADDR_W,
    parameter int LANES = sprpc_pkg::LANES,
    parameter int LANE_W = sprpc_pkg::LANE_W,
    parameter int PORTS = sprpc_pkg::PORTS
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // Address and counter controls, index 0 left, 1 right
    input wire logic [PORTS-1:0][ADDR_W-1:0] ADDR,
    input wire logic [PORTS-1:0] ADDRESS_STROBE_N,
    input wire logic [PORTS-1:0] COUNTER_ADVANCE_N,
    input wire logic [PORTS-1:0] COUNTER_CLEAR_N,
    // Chip selects, direction and byte lanes
    input wire logic [PORTS-1:0] SELECT_ACTIVE_LOW,
    input wire logic [PORTS-1:0] SELECT_ACTIVE_HIGH,
    input wire logic [PORTS-1:0] RW,
    input wire logic [PORTS-1:0][LANES-1:0] BYTE_LANE_ENABLE_N,
    // Asynchronous output enable
    input wire logic [PORTS-1:0] OE_N,
    // Data pins as input, output and output enable
    input wire logic [PORTS-1:0][LANES*LANE_W-1:0] DQ_IN,
    output logic [PORTS-1:0][LANES*LANE_W-1:0] DQ_OUT,
    output logic [PORTS-1:0][LANES*LANE_W-1:0] DQ_OE
);
    import sprpc_pkg::*;

    localparam int DW = LANES * LANE_W;
    localparam int DEPTH = 1 << ADDR_W;

    // Storage array shared by both ports
    logic [DW-1:0] mem [0:DEPTH-1];

    // Registered write requests handed from each port to the array
    logic [PORTS-1:0] wr_go;
    logic [ADDR_W-1:0] wr_addr [PORTS];
    logic [DW-1:0] wr_data [PORTS];
    logic [LANES-1:0] wr_lane [PORTS];

    // Counter carriers, one per port
    sprpc_cnt_if #(.ADDR_W(ADDR_W)) cnt_bus [PORTS] ();

    genvar p;
    generate
        for (p = 0; p < PORTS; p++) begin : g_port
            logic [ADDR_W-1:0] acc_addr;
            logic sel_now;
            sprpc_pwr_t pwr_reg;
            sprpc_pwr_t pwr_next;
            logic rw_reg;
            logic [LANES-1:0] lane_n_reg;
            logic [DW-1:0] din_reg;
            logic [DW-1:0] dout_reg;
            logic [DW-1:0] dout_next;
            logic [LANES-1:0] drive_reg;
            logic [LANES-1:0] drive_next;
            logic port_up;
            logic port_active;

            // Counter controls straight from the pins
            // (R1) strobe picks external address
            // (R5) clear needs no dead cycle
            assign cnt_bus[p].clear_n = COUNTER_CLEAR_N[p];
            assign cnt_bus[p].load_n = ADDRESS_STROBE_N[p];
            assign cnt_bus[p].advance_n = COUNTER_ADVANCE_N[p];
            assign cnt_bus[p].ext_addr = ADDR[p];

            // Own counter per port
            // (R20) independent port counter
            sprpc_addr_counter #(.ADDR_W(ADDR_W)) u_cnt (
                .clk(CLK),
                .srst(SRST),
                .cnt(cnt_bus[p])
            );

            // Counter register holds the address of this cycle's access
            // (R3) advanced address accessed
            // (R6) clear accesses zero
            assign acc_addr = cnt_bus[p].addr;

            // Both selects active
            assign sel_now = ~SELECT_ACTIVE_LOW[p] & SELECT_ACTIVE_HIGH[p];

            // Power state walks up one step per selected cycle
            // (R11) deselect powers down
            // (R12) two-cycle reactivation
            always_comb begin
                case (pwr_reg)
                    PWR_DOWN: pwr_next = sel_now ? PWR_WAKE : PWR_DOWN;
                    PWR_WAKE: pwr_next = sel_now ? PWR_ACTIVE : PWR_DOWN;
                    PWR_ACTIVE: pwr_next = sel_now ? PWR_ACTIVE : PWR_DOWN;
                    default: pwr_next = PWR_DOWN;
                endcase
            end

            // Decoded state of the cycle just registered
            assign port_up = (pwr_reg != PWR_DOWN);
            assign port_active = (pwr_reg == PWR_ACTIVE);

            // Input registers for controls and write data
            // (R8) rising-edge capture
            always_ff @(posedge CLK) begin
                if (SRST) begin
                    pwr_reg <= PWR_DOWN;
                    rw_reg <= RW_READ;
                    lane_n_reg <= LANES_OFF_N;
                    din_reg <= DATA_ZERO;
                end else begin
                    pwr_reg <= pwr_next;
                    rw_reg <= RW[p];
                    lane_n_reg <= BYTE_LANE_ENABLE_N[p];
                    din_reg <= DQ_IN[p];
                end
            end

            // Write request for the array, from registered values only
            // (R9) self-timed registered write
            assign wr_go[p] = port_up & ~rw_reg;
            assign wr_addr[p] = acc_addr;
            assign wr_data[p] = din_reg;
            assign wr_lane[p] = ~lane_n_reg;

            // Read data and lane drive for the next cycle
            // (R16) same address, same data
            // (R17) deselect or lane off floats
            assign dout_next = port_up ? mem[acc_addr] : dout_reg;
            assign drive_next = (port_active & rw_reg) ? ~lane_n_reg : LANES_OFF;

            // Output stage, one edge after the access registers
            // (R7) previous-cycle controls decide
            // (R15) data two cycles on
            always_ff @(posedge CLK) begin
                if (SRST) begin
                    dout_reg <= DATA_ZERO;
                    drive_reg <= LANES_OFF;
                end else begin
                    dout_reg <= dout_next;
                    drive_reg <= drive_next;
                end
            end

            // Pin drivers; enable is gated with no clock involved
            // (R10) asynchronous output enable
            assign DQ_OUT[p] = dout_reg;
            assign DQ_OE[p] = sprpc_lane_mask(drive_reg) & {DW{~OE_N[p]}};
        end
    endgenerate

    // Array writes; the left port is applied last, so it wins a same-word clash
    always_ff @(posedge CLK) begin
        for (int q = PORTS - 1; q >= 0; q--) begin
            if (wr_go[q]) begin
                for (int l = 0; l < LANES; l++) begin
                    if (wr_lane[q][l]) begin
                        mem[wr_addr[q]][l*LANE_W +: LANE_W] <= wr_data[q][l*LANE_W +: LANE_W];
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/sprpc_port_ram_assertions.sv ----
/* Checker on the port RAM top ports, mostly the left port.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module sprpc_port_ram_assertions #(
    parameter int LANES = 4,
    parameter int LANE_W = 9,
    parameter int PORTS = 2
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // Controls
    input wire logic [PORTS-1:0] ADDRESS_STROBE_N,
    input wire logic [PORTS-1:0] COUNTER_ADVANCE_N,
    input wire logic [PORTS-1:0] COUNTER_CLEAR_N,
    input wire logic [PORTS-1:0] SELECT_ACTIVE_LOW,
    input wire logic [PORTS-1:0] SELECT_ACTIVE_HIGH,
    input wire logic [PORTS-1:0] RW,
    input wire logic [PORTS-1:0][LANES-1:0] BYTE_LANE_ENABLE_N,
    input wire logic [PORTS-1:0] OE_N,
    // Data outputs
    input wire logic [PORTS-1:0][LANES*LANE_W-1:0] DQ_OUT,
    input wire logic [PORTS-1:0][LANES*LANE_W-1:0] DQ_OE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    // Deselect, full read and stalled read conditions
    wire [PORTS-1:0] desel = SELECT_ACTIVE_LOW | ~SELECT_ACTIVE_HIGH;
    wire rd = !desel[0] && RW[0] && BYTE_LANE_ENABLE_N[0] == '0;
    wire stall = RW[0] && RW[1] && ADDRESS_STROBE_N[0] && COUNTER_ADVANCE_N[0] && COUNTER_CLEAR_N[0];
    sequence wake_up;
        desel[0] ##1 (!desel[0])[*2];
    endsequence
    sequence full_reads;
        rd[*3];
    endsequence
    reset_quiet_a: assert property ($fell(SRST) |-> DQ_OE == '0)
        else $error("drivers on after reset");
    left_float_a: assert property (desel[0] |-> ##2 DQ_OE[0] == '0)
        else $error("left port drives after deselect");
    right_float_a: assert property (desel[1] |-> ##2 DQ_OE[1] == '0)
        else $error("right port drives after deselect");
    oe_gate_a: assert property (OE_N[0] |-> DQ_OE[0] == '0)
        else $error("drives with output enable off");
    wake_wait_a: assert property (wake_up |=> DQ_OE[0] == '0)
        else $error("drivers back too early");
    lane_float_a: assert property (BYTE_LANE_ENABLE_N[0][0] |-> ##2 DQ_OE[0][LANE_W-1:0] == '0)
        else $error("disabled lane driven");
    read_drive_a: assert property (full_reads ##1 !OE_N[0] |-> DQ_OE[0] == '1)
        else $error("active read not driven");
    data_hold_a: assert property (stall[*4] |=> $stable(DQ_OUT[0]))
        else $error("held read changed");
endmodule
bind sprpc_port_ram sprpc_port_ram_assertions #(.LANES(LANES), .LANE_W(LANE_W), .PORTS(PORTS)) chk_i (
    .CLK(CLK), .SRST(SRST), .ADDRESS_STROBE_N(ADDRESS_STROBE_N), .COUNTER_ADVANCE_N(COUNTER_ADVANCE_N),
    .COUNTER_CLEAR_N(COUNTER_CLEAR_N), .SELECT_ACTIVE_LOW(SELECT_ACTIVE_LOW), .SELECT_ACTIVE_HIGH(SELECT_ACTIVE_HIGH),
    .RW(RW), .BYTE_LANE_ENABLE_N(BYTE_LANE_ENABLE_N), .OE_N(OE_N), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE));
`default_nettype wire

// ---- tb/sprpc_host_bus.sv ----
/* Host side of one port's data pins: drives write data, resolves the wire.
   Assumes drive requests change just after clock edges. */
`timescale 1ns/1ps
`default_nettype none
module sprpc_host_bus (
    // Clock
    input wire logic clk,
    // Host drive request
    input wire logic drive_en,
    input wire logic [sprpc_pkg::DATA_W-1:0] drive_data,
    // Device pins and resolved level
    input wire logic [sprpc_pkg::DATA_W-1:0] dq_out,
    input wire logic [sprpc_pkg::DATA_W-1:0] dq_oe,
    output logic [sprpc_pkg::DATA_W-1:0] dq_bus
);
    import sprpc_pkg::*;
    logic [DATA_W-1:0] last_reg = DATA_ZERO;
    // Device bits win; floating bits show the host write word while it drives, else the inverse
    // of the bus level sampled at the last clock edge
    assign dq_bus = (dq_oe & dq_out) | (~dq_oe & (drive_en ? drive_data : ~last_reg));
    // Remember the level for the next float
    always_ff @(posedge clk) last_reg <= dq_bus;
endmodule
`default_nettype wire

// ---- tb/sprpc_port_ram_test.sv ----
/* Self-checking bench for the port RAM: bursts, clears, lanes, selects, enable.
   Assumes the host bus model and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module sprpc_port_ram_test;
    import sprpc_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [PORTS-1:0][ADDR_W-1:0] addr = '0;
    logic [PORTS-1:0] as_n = '1, adv_n = '1, clr_n = '1, sel_l = '1, sel_h = '0, rw = '1, oe_n = '0;
    logic [PORTS-1:0][LANES-1:0] lane_n = '1;
    logic [PORTS-1:0][DATA_W-1:0] wdata = '0, dq_out, dq_oe;
    wire [PORTS-1:0][DATA_W-1:0] bus;
    logic [DATA_W-1:0] d [4] = '{36'hA5A5A5A5A, 36'h5A5A5A5A5, 36'h0F0F0F0F0, 36'h123456789};
    logic [DATA_W-1:0] mix = 36'h222222222 & ~36'h007FC0000 | 36'h111111111 & 36'h007FC0000;
    int num_errors = 0, n_checks = 0, cycles = 0;
    initial forever #12.5 clk = ~clk;
    sprpc_port_ram dut (.CLK(clk), .SRST(srst), .ADDR(addr), .ADDRESS_STROBE_N(as_n), .COUNTER_ADVANCE_N(adv_n),
        .COUNTER_CLEAR_N(clr_n), .SELECT_ACTIVE_LOW(sel_l), .SELECT_ACTIVE_HIGH(sel_h), .RW(rw),
        .BYTE_LANE_ENABLE_N(lane_n), .OE_N(oe_n), .DQ_IN(bus), .DQ_OUT(dq_out), .DQ_OE(dq_oe));
    for (genvar p = 0; p < PORTS; p++) begin : g_host
        sprpc_host_bus host (.clk(clk), .drive_en(~rw[p]), .drive_data(wdata[p]), .dq_out(dq_out[p]),
            .dq_oe(dq_oe[p]), .dq_bus(bus[p]));
    end
    // Report the counts and the verdict, then stop
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Compare one observed value with its expectation
    task automatic chk(input string what, input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Present one left request at an edge; that edge's outputs are settled on return
    task automatic step(input logic [5:0] c, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
        input logic [LANES-1:0] ln);
        @(posedge clk);
        {sel_l[0], sel_h[0], as_n[0], adv_n[0], clr_n[0], rw[0]} <= c;
        addr[0] <= a;
        wdata[0] <= wd;
        lane_n[0] <= ln;
        #1;
    endtask
    task automatic t_burst();
        logic [5:0] c [16] = '{6'h16, 6'h1A, 6'h1A, 6'h10, 6'h1D, 6'h17, 6'h1B, 6'h1B,
            6'h1F, 6'h1F, 6'h1F, 6'h13, 6'h1F, 6'h1F, 6'h1F, 6'h1F};
        int e [16] = '{0, 0, 0, 0, 3, 0, 1, 3, 3, 3, 3, 0, 0, 0, 0, 0};
        for (int i = 0; i < 16; i++) begin
            step(c[i], (i % 5 == 0 || i == 11) ? 15'h7FFE : 15'h1234, d[i % 4], 4'h0);
            if (i >= 2 && c[i-2][0] === 1'b1) chk("burst word", bus[0], d[e[i-2]]);
        end
    endtask
    task automatic t_lanes();
        // Two lane-less writes let the burst reads release the bus first
        step(6'h1E, 15'h1234, '0, 4'hF);
        step(6'h1E, 15'h1234, '0, 4'hF);
        step(6'h16, 15'h0100, 36'h111111111, 4'h0);
        step(6'h16, 15'h0100, 36'h222222222, 4'h4);
        step(6'h17, 15'h0100, '0, 4'h2);
        step(6'h1F, 15'h1234, '0, 4'h2);
        step(6'h1F, 15'h1234, '0, 4'h2);
        chk("lane drive", dq_oe[0], ~36'h00003FE00);
        chk("lane data", bus[0] & ~36'h00003FE00, mix & ~36'h00003FE00);
    endtask
    task automatic t_desel();
        logic [1:0] off [2] = '{2'b11, 2'b00};
        for (int j = 0; j < 2; j++) begin
            // Full-lane read before the deselect still drives in its cycle
            step(6'h1F, 15'h1234, '0, 4'h0);
            step({off[j], 4'hF}, 15'h1234, '0, 4'h0);
            for (int i = 1; i <= 4; i++) begin
                step(6'h1F, 15'h1234, '0, 4'h0);
                chk("wake drive", dq_oe[0], {DATA_W{(i == 1) || (i == 4)}});
            end
            chk("wake data", bus[0], mix);
        end
    endtask
    task automatic t_oe();
        @(posedge clk);
        oe_n[0] <= 1'b1;
        #1;
        chk("enable off", dq_oe[0], '0);
        @(posedge clk);
        oe_n[0] <= 1'b0;
        #1;
        chk("enable on", dq_oe[0], '1);
    endtask
    task automatic t_right();
        @(posedge clk);
        {sel_l[1], sel_h[1], as_n[1], rw[1], lane_n[1]} <= 8'h40;
        addr[1] <= 15'h0200;
        wdata[1] <= 36'h3C3C3C3C3;
        step(6'h1F, 15'h1234, '0, 4'h0);
        step(6'h1F, 15'h1234, '0, 4'h0);
        chk("left kept", bus[0], mix);
        step(6'h17, 15'h0200, '0, 4'h0);
        step(6'h1F, 15'h1234, '0, 4'h0);
        step(6'h1F, 15'h1234, '0, 4'h0);
        chk("right word", bus[0], 36'h3C3C3C3C3);
        @(posedge clk);
        rw[1] <= 1'b1;
        addr[1] <= 15'h0100;
        repeat (2) @(posedge clk);
        #1;
        chk("right drive", dq_oe[1], '1);
        chk("right read", bus[1], mix);
    endtask
    // Cut a hung run short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 500) begin
            num_errors++;
            finish_test();
        end
    end
    // Reset, then the scenarios in order
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        t_burst();
        t_lanes();
        t_desel();
        t_oe();
        t_right();
        finish_test();
    end
endmodule
`default_nettype wire
